// *** qpfe_pkg.sv ***
// Behaviour
// - the oscillator input clock is divided by four into four non-overlapping phases in fixed order.
// - one instruction cycle is exactly four phase periods and all timing follows the phases.
// - the program counter increments in phase one, starting the fetch cycle.
// - the word read from program memory is captured into the fetch register at phase four and moved into the instruction latch at the next phase one.
// - the latched instruction is presented at phase one and decoded and executed in phases two to four.
// - fetch of the next instruction overlaps execution of the current one, one per cycle.
// - an instruction that changes the program counter takes two instruction cycles.
// - after a program counter change the already fetched instruction executes as no operation.
// - the data memory operand read happens in phase two of the execution cycle.
// - the data memory destination write happens in phase four of the execution cycle.
// - master clear is an active-low reset held high by external logic for normal operation.
package qpfe_pkg;
  // ---------------------------------------------
  // phase encoding
  // ---------------------------------------------
  typedef enum logic [1:0] {
    QPFE_PH_ONE   = 2'b00,
    QPFE_PH_TWO   = 2'b01,
    QPFE_PH_THREE = 2'b10,
    QPFE_PH_FOUR  = 2'b11
  } qpfe_phase_t;

  // ---------------------------------------------
  // widths and reset values
  // ---------------------------------------------
  localparam int                 QPFE_PHASES_PER_CYCLE = 4;
  localparam int                 QPFE_PC_WIDTH         = 13;
  localparam int                 QPFE_INSN_WIDTH       = 14;
  localparam logic [12:0]        QPFE_PC_RESET         = 13'h0000;
  localparam logic [13:0]        QPFE_NOP_WORD         = 14'h0000;
endpackage

// *** qpfe_phase_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module qpfe_phase_gen (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  output qpfe_pkg::qpfe_phase_t   phase_out,
  output logic              [3:0] phase_onehot_out
);
  qpfe_pkg::qpfe_phase_t phase_reg;

  // ---------------------------------------------
  // divide by four
  // ---------------------------------------------
  // held, restart at one
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      phase_reg <= qpfe_pkg::QPFE_PH_ONE;
    end else begin
      phase_reg <= qpfe_pkg::qpfe_phase_t'(phase_reg + 2'b01);
    end
  end

  assign phase_out = phase_reg;

  // one hot decode, exactly one active out of reset, none while reset is held
  genvar i;
  generate
    for (i = 0; i < qpfe_pkg::QPFE_PHASES_PER_CYCLE; i++) begin : g_ph
      assign phase_onehot_out[i] = (phase_reg == 2'(i)) && !rst_in;
    end
  endgenerate
endmodule
`default_nettype wire

// *** qpfe_pipeline.sv ***
`timescale 1ns/1ns
`default_nettype none
module qpfe_pipeline #(
  parameter int PC_WIDTH   = qpfe_pkg::QPFE_PC_WIDTH,
  parameter int INSN_WIDTH = qpfe_pkg::QPFE_INSN_WIDTH
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  master_clear_n_in,
  input  wire logic                  resistor_capacitor_osc_mode_in,
  input  wire logic [INSN_WIDTH-1:0] prog_data_in,
  input  wire logic                  jump_instruction_in,
  input  wire logic [PC_WIDTH-1:0]   jump_target_in,
  output logic      [PC_WIDTH-1:0]   program_counter_out,
  output logic      [INSN_WIDTH-1:0] instruction_latch_out,
  output logic                       insn_valid_out,
  output logic                       phase_one_out,
  output logic                       phase_two_out,
  output logic                       phase_three_out,
  output logic                       phase_four_out,
  output logic                       data_read_out,
  output logic                       data_write_out,
  output logic                       osc_out_quarter_clock_out
);
  // ---------------------------------------------
  // reset and phases
  // ---------------------------------------------
  logic                  rst;
  qpfe_pkg::qpfe_phase_t phase;
  logic [3:0]            ph;
  logic [PC_WIDTH-1:0]   pc_reg;
  logic [PC_WIDTH-1:0]   target_reg;
  logic [INSN_WIDTH-1:0] fetch_reg;
  logic [INSN_WIDTH-1:0] insn_reg;
  logic                  valid_reg;
  logic                  flush_reg;
  logic                  clkout_reg;

  assign rst = !master_clear_n_in;

  qpfe_phase_gen u_phase (
    .clk_sys_in       (clk_sys_in),
    .rst_in           (rst),
    .phase_out        (phase),
    .phase_onehot_out (ph)
  );

  assign phase_one_out   = ph[0];
  assign phase_two_out   = ph[1];
  assign phase_three_out = ph[2];
  assign phase_four_out  = ph[3];

  // ---------------------------------------------
  // program counter
  // ---------------------------------------------
  // hold target until next phase one
  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      target_reg <= PC_WIDTH'(qpfe_pkg::QPFE_PC_RESET);
    end else if (ph[3] && jump_instruction_in && valid_reg) begin
      target_reg <= jump_target_in;
    end
  end

  // target loads in place of the increment, so the target word is fetched itself
  // reset flush steers the first fetch to the reset address
  // increment in phase one
  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      pc_reg <= PC_WIDTH'(qpfe_pkg::QPFE_PC_RESET);
    end else if (ph[0] && flush_reg) begin
      pc_reg <= target_reg;
    end else if (ph[0]) begin
      pc_reg <= pc_reg + PC_WIDTH'(1);
    end
  end
  assign program_counter_out = pc_reg;

  // ---------------------------------------------
  // fetch and instruction latch
  // ---------------------------------------------
  // capture fetched word at phase four
  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      fetch_reg <= INSN_WIDTH'(qpfe_pkg::QPFE_NOP_WORD);
    end else if (ph[3]) begin
      fetch_reg <= prog_data_in;
    end
  end

  // flush marks the cycle after a jump; fetched word is stale
  // discard fetched instruction
  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      flush_reg <= 1'b1;
    end else if (ph[3]) begin
      flush_reg <= jump_instruction_in && valid_reg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      insn_reg  <= INSN_WIDTH'(qpfe_pkg::QPFE_NOP_WORD);
      valid_reg <= 1'b0;
    end else if (ph[0]) begin
      insn_reg  <= flush_reg ? INSN_WIDTH'(qpfe_pkg::QPFE_NOP_WORD) : fetch_reg;
      valid_reg <= !flush_reg;
    end
  end
  assign instruction_latch_out = insn_reg;
  assign insn_valid_out        = valid_reg;

  // ---------------------------------------------
  // data memory strobes
  // ---------------------------------------------
  // operand read phase two
  assign data_read_out  = ph[1] && valid_reg;
  assign data_write_out = ph[3] && valid_reg;

  // ---------------------------------------------
  // quarter clock output
  // ---------------------------------------------
  // high in phases three and four
  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      clkout_reg <= 1'b0;
    end else begin
      clkout_reg <= resistor_capacitor_osc_mode_in &&
                    (phase == qpfe_pkg::QPFE_PH_TWO || phase == qpfe_pkg::QPFE_PH_THREE);
    end
  end
  assign osc_out_quarter_clock_out = clkout_reg;
endmodule
`default_nettype wire

// *** qpfe_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module qpfe_asserts (
  input wire logic        clk_sys_in,
  input wire logic        master_clear_n_in,
  input wire logic        resistor_capacitor_osc_mode_in,
  input wire logic        jump_instruction_in,
  input wire logic [12:0] jump_target_in,
  input wire logic [12:0] program_counter_out,
  input wire logic [13:0] instruction_latch_out,
  input wire logic        insn_valid_out,
  input wire logic        phase_one_out,
  input wire logic        phase_two_out,
  input wire logic        phase_three_out,
  input wire logic        phase_four_out,
  input wire logic        data_read_out,
  input wire logic        data_write_out,
  input wire logic        osc_out_quarter_clock_out
);
  // ----
  // timing checks
  // ----
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!master_clear_n_in);
  wire logic [3:0] ph = {phase_four_out, phase_three_out, phase_two_out, phase_one_out};
  wire logic       v  = insn_valid_out;
  sequence s_quad; ph[1] ##1 ph[2] ##1 ph[3] ##1 ph[0]; endsequence
  sequence s_flush; !v && instruction_latch_out == 14'h0 ##4 v; endsequence
  a_phase_onehot: assert property ($past(master_clear_n_in) |-> $onehot(ph))
    else $error("phase not one-hot");
  a_phase_order: assert property (ph[0] |=> s_quad)
    else $error("phase order");
  a_reset_start: assert property ($rose(master_clear_n_in) |-> ##[0:1] ph[0])
    else $error("no phase one after reset");
  a_pc_step: assert property (ph[0] ##1 v |->
    program_counter_out == $past(program_counter_out) + 13'h1) else $error("pc step");
  a_jump_target: assert property (ph[3] && v && jump_instruction_in |->
    ##2 program_counter_out == $past(jump_target_in, 2)) else $error("jump target");
  a_latch_hold: assert property (!ph[0] |=> $stable(instruction_latch_out))
    else $error("latch moved");
  a_jump_flush: assert property (ph[3] && v && jump_instruction_in |-> ##2 s_flush)
    else $error("jump flush");
  a_read_phase: assert property (data_read_out == (ph[1] && v))
    else $error("read phase");
  a_write_phase: assert property (data_write_out == (ph[3] && v))
    else $error("write phase");
  a_clkout_rate: assert property (resistor_capacitor_osc_mode_in && ph[0] |->
    !osc_out_quarter_clock_out ##1 !osc_out_quarter_clock_out ##1 osc_out_quarter_clock_out
    ##1 osc_out_quarter_clock_out) else $error("clock out rate");
  a_clkout_off: assert property (!resistor_capacitor_osc_mode_in |=>
    !osc_out_quarter_clock_out) else $error("clock out in wrong mode");
endmodule
`default_nettype wire

// *** qpfe_prog_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module qpfe_prog_mem (
  input  wire logic [12:0] addr_in,
  output logic      [13:0] word_out
);
  assign word_out = {addr_in[0], addr_in} ^ 14'h2c5a;
endmodule
`default_nettype wire

// *** tb_quad_phase_fetch_execute_pipeline.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_quad_phase_fetch_execute_pipeline;
  // ----
  // bench
  // ----
  logic        clk = 1'b0;
  logic        clr_n = 1'b0;
  logic        rc = 1'b0;
  logic        jmp = 1'b0;
  logic [12:0] tgt = 13'h0;
  logic [12:0] pc;
  logic [13:0] word;
  logic [13:0] latch;
  logic        v, p1, p2, p3, p4, ck;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic        flush_due = 1'b0;
  logic        target_due = 1'b0;
  logic [12:0] tgt_seen = 13'h0;
  always #10 clk = ~clk;
  qpfe_prog_mem mem (.addr_in(pc), .word_out(word));
  qpfe_pipeline uut (.clk_sys_in(clk), .master_clear_n_in(clr_n),
    .resistor_capacitor_osc_mode_in(rc), .prog_data_in(word), .jump_instruction_in(jmp),
    .jump_target_in(tgt), .program_counter_out(pc), .instruction_latch_out(latch),
    .insn_valid_out(v), .phase_one_out(p1), .phase_two_out(p2), .phase_three_out(p3),
    .phase_four_out(p4), .data_read_out(), .data_write_out(), .osc_out_quarter_clock_out(ck));
  function automatic logic [19:0] exp_word(input logic [12:0] a);
    return 20'({a[0], a} ^ 14'h2c5a);
  endfunction
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apply_reset;
    clr_n <= 1'b0;
    jmp   <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(20'({v, p1, p2, p3, p4, ck, pc}), 20'h0);
    check(20'(latch), 20'h0);
    @(posedge clk);
    clr_n <= 1'b1;
    @(negedge clk);
    check(20'({p1, p2, p3, p4, v}), 20'h10);
  endtask
  // ceiling well above the 2208 cycle run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  always @(negedge clk) begin
    if (!clr_n) begin
      flush_due = 1'b0;
      target_due = 1'b0;
    end
    if (clr_n && p2 && v) check(20'(latch), exp_word(pc - 13'h1));
    if (clr_n && p2 && target_due) begin
      check(20'({v, latch}), 20'h4000 | exp_word(tgt_seen));
      target_due = 1'b0;
    end
    if (clr_n && p2 && flush_due) begin
      check(20'({v, latch}), 20'h0);
      flush_due = 1'b0;
      target_due = 1'b1;
    end
    // jump as the design will sample it at the coming edge
    if (clr_n && p4 && v && jmp) begin
      flush_due = 1'b1;
      tgt_seen = tgt;
    end
    if (cyc == 300) check(20'(ck), 20'h0);
    if (clr_n && rc && cyc > 410) check(20'(ck), 20'(p3 | p4));
  end
  initial begin
    void'($urandom(68));
    apply_reset();
    // jumps drawn often so back-to-back and top-of-memory targets occur
    repeat (2000) @(posedge clk) begin
      jmp <= ($urandom % 5) == 0;
      tgt <= (cyc % 97 == 0) ? 13'h1fff : 13'($urandom);
      rc <= cyc > 400;
    end
    // second release in mid-run, mode left on
    apply_reset();
    repeat (200) @(posedge clk) begin
      jmp <= ($urandom % 5) == 0;
      tgt <= 13'($urandom);
    end
    print_verdict();
  end
endmodule
bind qpfe_pipeline qpfe_asserts chk (.clk_sys_in, .master_clear_n_in,
  .resistor_capacitor_osc_mode_in, .jump_instruction_in, .jump_target_in, .program_counter_out,
  .instruction_latch_out, .insn_valid_out, .phase_one_out, .phase_two_out, .phase_three_out,
  .phase_four_out, .data_read_out, .data_write_out, .osc_out_quarter_clock_out);
`default_nettype wire
